/* File: src/clk_rst_pkg.sv */
// Constants, field layout and state types for the clock and reset glue.
// Assumes one clock (hclk, the clock generator main output) and AHB-Lite access.
package clk_rst_pkg;
    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_HZ                 = 20_000_000;
    localparam int unsigned CLK_PERIOD_NS          = 50;
    localparam int unsigned BUS_DIV                = 2;   // Main output to bus clock ratio
    localparam int unsigned RESET_DRIVE_BUS_CYCLES = 66;
    localparam logic [7:0]  RESET_DRIVE_LAST       = 8'(RESET_DRIVE_BUS_CYCLES * BUS_DIV - 1);
    localparam logic [3:0]  FF_MIN_GAP_M1          = 4'(2 * BUS_DIV - 1);  // Half bus rate
    localparam logic [3:0]  EXT_MIN_GAP_M1         = 4'(4 * BUS_DIV - 1);  // Quarter bus rate
    localparam logic [3:0]  GAP_RESET              = 4'hf;
    localparam int unsigned BDC_BIT_TICKS          = 16;
    localparam logic [3:0]  BDC_BIT_LAST           = 4'(BDC_BIT_TICKS - 1);
    localparam logic [3:0]  BDC_LOW_ONE_M1         = 4'h3;
    localparam logic [3:0]  BDC_LOW_ZERO_M1        = 4'hc;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [7:0]  CTRL_OFS    = 8'h00;
    localparam logic [7:0]  CAUSE_OFS   = 8'h04;
    localparam logic [7:0]  STATUS_OFS  = 8'h08;
    localparam logic [7:0]  BDC_TX_OFS  = 8'h0c;
    // CTRL fields
    localparam int unsigned CTRL_MAIN_LSB  = 0;
    localparam int unsigned CTRL_BDC_BIT   = 2;
    localparam int unsigned CTRL_TIMER_LSB = 3;
    localparam int unsigned CTRL_RTC_LSB   = 5;
    localparam int unsigned CTRL_ADC_BIT   = 7;
    localparam int unsigned CTRL_COP_BIT   = 8;
    localparam logic [8:0]  CTRL_RESET     = 9'h000;
    // CAUSE fields
    localparam int unsigned CAUSE_POR    = 0;
    localparam int unsigned CAUSE_PIN    = 1;
    localparam int unsigned CAUSE_WDOG   = 2;
    localparam int unsigned CAUSE_ILLOP  = 3;
    localparam int unsigned CAUSE_ILLADR = 4;
    localparam int unsigned CAUSE_LVD    = 5;
    localparam logic [5:0]  CAUSE_RESET  = 6'h01;
    // STATUS fields
    localparam int unsigned ST_FF_ERR  = 0;
    localparam int unsigned ST_EXT_ERR = 1;
    localparam int unsigned ST_BDM     = 2;
    localparam int unsigned ST_BUSY    = 3;
    localparam int unsigned ST_FIXED_FREQ_CLOCK   = 4;

    // ----------------------------------------------------------------
    // Synchroniser lanes
    // ----------------------------------------------------------------
    localparam int unsigned SYNC_N    = 5;
    localparam int unsigned SY_FF     = 0;
    localparam int unsigned SY_EXT    = 1;
    localparam int unsigned SY_DCO    = 2;
    localparam int unsigned SY_RSTPIN = 3;
    localparam int unsigned SY_BKGD   = 4;
    localparam logic [4:0]  SYNC_INIT = 5'h18;  // Pins idle high

    typedef enum logic [1:0] {SRC_INTERNAL, SRC_EXTERNAL, SRC_LOOP} main_src_type;
    typedef enum logic [1:0] {RST_DRIVE, RST_WAIT_PIN, RST_RUN} rst_state_type;
    typedef enum logic [1:0] {BDC_IDLE, BDC_LOW, BDC_SPEED, BDC_REST} bdc_state_type;
endpackage

/* File: src/clock_sync_edge.sv */
// Two-stage synchroniser with rising-edge detect for asynchronous inputs.
// Assumes inputs may change at any time relative to hclk.
module clock_sync_edge
    import clk_rst_pkg::*;
(
    input  logic              hclk,
    input  logic              hresetn,
    input  logic [SYNC_N-1:0] async_in,
    sync_if.src               so
);
    logic [SYNC_N-1:0] meta_q;
    logic [SYNC_N-1:0] sync_q;
    logic [SYNC_N-1:0] prev_q;
    logic [SYNC_N-1:0] prev_d;

    // ----------------------------------------------------------------
    // Stages
    // ----------------------------------------------------------------
    // Edge detect looks only at the second stage, never at meta_q
    always_comb begin
        prev_d   = sync_q;
        so.level = sync_q;
        so.rise  = sync_q & ~prev_q;
    end

    // Register stages
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_q <= SYNC_INIT;
            sync_q <= SYNC_INIT;
            prev_q <= SYNC_INIT;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
            prev_q <= prev_d;
        end
    end
endmodule // clock_sync_edge

/* File: src/sync_if.sv */
// Carries synchronised levels and their rising-edge pulses.
// Assumes producer and consumer share hclk.
interface sync_if #(parameter int N = 5) ();
    logic [N-1:0] level;
    logic [N-1:0] rise;
    modport src (output level, output rise);
    modport dst (input level, input rise);
endinterface

/* File: src/sys_clock_reset.sv */
// Clock distribution, reset pin pulse, reset cause and mode select glue.
// Assumes hclk is the clock generator main output; AHB-Lite slave on hclk.
//
// Decided for this implementation: the placing of the registers and register access over AHB-Lite.
module sys_clock_reset
    import clk_rst_pkg::*;
(
    input  logic        hclk,
    input  logic        hresetn,
    input  logic        hsel,
    input  logic [31:0] haddr,
    input  logic [1:0]  htrans,
    input  logic        hwrite,
    input  logic [2:0]  hsize,
    input  logic [31:0] hwdata,
    input  logic        hready,
    output logic [31:0] hrdata,
    output logic        hreadyout,
    output logic        hresp,
    input  logic        fixed_freq_source_clock,
    input  logic        timer_external_clock,
    input  logic        dco_local_clock,
    input  logic        watchdog_reset_req,
    input  logic        illegal_op_req,
    input  logic        illegal_addr_req,
    input  logic        low_voltage_req,
    input  logic        reset_pin_in,
    output logic        reset_pin_out,
    output logic        reset_pin_oe,
    input  logic        debug_modeselect_pin_in,
    output logic        debug_modeselect_pin_out,
    output logic        debug_modeselect_pin_oe,
    output logic        peripheral_bus_clock,
    output logic [1:0]  main_src_sel,
    output logic [1:0]  timer_src_sel,
    output logic [1:0]  rtc_src_sel,
    output logic        adc_src_ext_ref,
    output logic        watchdog_src_lpo,
    output logic        bdc_clk_sel_dco,
    output logic        fixed_freq_clock,
    output logic        timer_tick,
    output logic        system_reset_n,
    output logic        background_mode
);
    sync_if #(.N(SYNC_N)) sy ();

    // Asynchronous pins and clocks enter through the synchroniser
    clock_sync_edge u_sync (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .async_in ({debug_modeselect_pin_in, reset_pin_in, dco_local_clock,
                    timer_external_clock, fixed_freq_source_clock}),
        .so       (sy.src)
    );

    function automatic logic [3:0] sat_inc(input logic [3:0] v);
        sat_inc = (v == 4'hf) ? v : v + 4'h1;
    endfunction

    // ----------------------------------------------------------------
    // Bus slave
    // ----------------------------------------------------------------
    logic        bus_clk_q, bus_clk_d;
    logic        dp_wr_q, dp_wr_d;
    logic [7:0]  dp_addr_q, dp_addr_d;
    logic        ready_q, ready_d;
    logic [31:0] rdata_q, rdata_d;
    logic        take, commit;
    logic [8:0]  ctrl_q, ctrl_d;
    logic [5:0]  cause_q, cause_d;
    logic        ff_err_q, ff_err_d, ext_err_q, ext_err_d;
    logic        mode_bdm_q, mode_bdm_d;
    bdc_state_type bdc_q, bdc_d;

    function automatic logic [31:0] read_mux(input logic [7:0] a, input logic [8:0] c, input logic [5:0] r,
                                             input logic [4:0] s);
        unique case (a)
            CTRL_OFS:   read_mux = {23'h0, c};
            CAUSE_OFS:  read_mux = {26'h0, r};
            STATUS_OFS: read_mux = {27'h0, s};
            default:    read_mux = 32'h0;
        endcase
    endfunction

    // Writes stall one cycle when needed so they land on the bus-clock phase
    always_comb begin
        take      = hsel && hready && htrans[1];
        bus_clk_d = ~bus_clk_q;
        commit    = dp_wr_q && !bus_clk_q;
        dp_wr_d   = take ? hwrite : (dp_wr_q && bus_clk_q);
        dp_addr_d = take ? {haddr[7:2], 2'b00} : dp_addr_q;
        ready_d   = !(dp_wr_d && bus_clk_d);
        rdata_d   = (take && !hwrite) ?
                    read_mux({haddr[7:2], 2'b00}, ctrl_q, cause_q,
                             {fixed_freq_clock, bdc_q != BDC_IDLE, mode_bdm_q, ext_err_q, ff_err_q}) : 32'h0;
    end

    // Bus registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_clk_q <= 1'b0;
            dp_wr_q   <= 1'b0;
            dp_addr_q <= 8'h00;
            ready_q   <= 1'b1;
            rdata_q   <= 32'h0;
        end else begin
            bus_clk_q <= bus_clk_d;
            dp_wr_q   <= dp_wr_d;
            dp_addr_q <= dp_addr_d;
            ready_q   <= ready_d;
            rdata_q   <= rdata_d;
        end
    end

    // ----------------------------------------------------------------
    // Clock selection and derived clocks
    // ----------------------------------------------------------------
    rst_state_type rst_q, rst_d;
    logic       fixed_freq_clock_q, fixed_freq_clock_d, tick_q, tick_d;
    logic [3:0] ff_gap_q, ff_gap_d, ext_gap_q, ext_gap_d;
    logic       ff_viol, ext_viol, wr_status;

    // Selects fall back to reset values during any reset, so the
    // device always restarts from the internal reference
    always_comb begin
        ctrl_d = ctrl_q;
        // Clear in the same cycle that the run ends, so the source is internal all through reset
        if (rst_q != RST_RUN || rst_d != RST_RUN) begin
            ctrl_d = CTRL_RESET;
        end else if (commit && dp_addr_q == CTRL_OFS) begin
            ctrl_d = hwdata[8:0];
            if (hwdata[CTRL_MAIN_LSB+:2] == 2'b11) begin
                ctrl_d[CTRL_MAIN_LSB+:2] = ctrl_q[CTRL_MAIN_LSB+:2];
            end
        end
        fixed_freq_clock_d   = fixed_freq_clock_q ^ sy.rise[SY_FF];
        ff_gap_d  = sy.rise[SY_FF] ? 4'h0 : sat_inc(ff_gap_q);
        ext_gap_d = sy.rise[SY_EXT] ? 4'h0 : sat_inc(ext_gap_q);
        ff_viol   = sy.rise[SY_FF] && (ff_gap_q < FF_MIN_GAP_M1);
        ext_viol  = sy.rise[SY_EXT] && (ext_gap_q < EXT_MIN_GAP_M1);
        wr_status = commit && dp_addr_q == STATUS_OFS;
        // New violation wins over a simultaneous clear
        ff_err_d  = ff_viol | (ff_err_q & ~(wr_status & hwdata[ST_FF_ERR]));
        ext_err_d = ext_viol | (ext_err_q & ~(wr_status & hwdata[ST_EXT_ERR]));
        unique case (ctrl_q[CTRL_TIMER_LSB+:2])
            2'b01:   tick_d = sy.rise[SY_FF] && !fixed_freq_clock_q;
            2'b10:   tick_d = sy.rise[SY_EXT];
            default: tick_d = !bus_clk_q;
        endcase
    end

    // Clock selection registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q    <= CTRL_RESET;
            fixed_freq_clock_q   <= 1'b0;
            tick_q    <= 1'b0;
            ff_gap_q  <= GAP_RESET;
            ext_gap_q <= GAP_RESET;
            ff_err_q  <= 1'b0;
            ext_err_q <= 1'b0;
        end else begin
            ctrl_q    <= ctrl_d;
            fixed_freq_clock_q   <= fixed_freq_clock_d;
            tick_q    <= tick_d;
            ff_gap_q  <= ff_gap_d;
            ext_gap_q <= ext_gap_d;
            ff_err_q  <= ff_err_d;
            ext_err_q <= ext_err_d;
        end
    end

    // ----------------------------------------------------------------
    // Reset sequencing
    // ----------------------------------------------------------------
    logic [7:0] drive_cnt_q, drive_cnt_d;
    logic       rst_oe_q, rst_oe_d, run_q, run_d;

    // Pin is sensed while running and while waiting for release, not during the pulse that we drive ourselves
    always_comb begin
        rst_d       = rst_q;
        drive_cnt_d = drive_cnt_q;
        cause_d     = cause_q;
        mode_bdm_d  = mode_bdm_q;
        unique case (rst_q)
            RST_RUN: begin
                if (low_voltage_req || watchdog_reset_req || illegal_op_req || illegal_addr_req
                    || !sy.level[SY_RSTPIN]) begin
                    rst_d       = RST_DRIVE;
                    drive_cnt_d = 8'h00;
                    cause_d     = 6'h00;
                    if (low_voltage_req)         cause_d[CAUSE_LVD]    = 1'b1;
                    else if (watchdog_reset_req) cause_d[CAUSE_WDOG]   = 1'b1;
                    else if (illegal_op_req)     cause_d[CAUSE_ILLOP]  = 1'b1;
                    else if (illegal_addr_req)   cause_d[CAUSE_ILLADR] = 1'b1;
                    else                         cause_d[CAUSE_PIN]    = 1'b1;
                end
            end
            RST_DRIVE: begin
                drive_cnt_d = drive_cnt_q + 8'h01;
                if (drive_cnt_q == RESET_DRIVE_LAST) begin
                    rst_d = RST_WAIT_PIN;
                end
            end
            RST_WAIT_PIN: begin
                if (sy.level[SY_RSTPIN]) begin
                    rst_d      = RST_RUN;
                    mode_bdm_d = !sy.level[SY_BKGD];
                end
            end
        endcase
        rst_oe_d = (rst_d == RST_DRIVE);
        run_d    = (rst_d == RST_RUN);
    end

    // Reset registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rst_q       <= RST_DRIVE;
            drive_cnt_q <= 8'h00;
            cause_q     <= CAUSE_RESET;
            mode_bdm_q  <= 1'b0;
            rst_oe_q    <= 1'b1;
            run_q       <= 1'b0;
        end else begin
            rst_q       <= rst_d;
            drive_cnt_q <= drive_cnt_d;
            cause_q     <= cause_d;
            mode_bdm_q  <= mode_bdm_d;
            rst_oe_q    <= rst_oe_d;
            run_q       <= run_d;
        end
    end

    // ----------------------------------------------------------------
    // Debug pin bit transmitter
    // ----------------------------------------------------------------
    logic [3:0] bit_cnt_q, bit_cnt_d;
    logic       bit_val_q, bit_val_d, bdc_tick;
    logic       bkgd_oe_q, bkgd_oe_d, bkgd_out_q, bkgd_out_d;

    // One bit per write; the pin is left alone until reset has finished
    always_comb begin
        bdc_tick  = ctrl_q[CTRL_BDC_BIT] ? sy.rise[SY_DCO] : !bus_clk_q;
        bdc_d     = bdc_q;
        bit_cnt_d = bit_cnt_q;
        bit_val_d = bit_val_q;
        if (rst_q != RST_RUN) begin
            bdc_d = BDC_IDLE;
        end else begin
            unique case (bdc_q)
                BDC_IDLE: if (commit && dp_addr_q == BDC_TX_OFS) begin
                    bdc_d     = BDC_LOW;
                    bit_cnt_d = 4'h0;
                    bit_val_d = hwdata[0];
                end
                BDC_LOW: if (bdc_tick) begin
                    bit_cnt_d = bit_cnt_q + 4'h1;
                    if (bit_cnt_q == (bit_val_q ? BDC_LOW_ONE_M1 : BDC_LOW_ZERO_M1)) begin
                        bdc_d = BDC_SPEED;
                    end
                end
                BDC_SPEED: if (bdc_tick) begin
                    bit_cnt_d = bit_cnt_q + 4'h1;
                    bdc_d     = BDC_REST;
                end
                BDC_REST: if (bdc_tick) begin
                    bit_cnt_d = bit_cnt_q + 4'h1;
                    if (bit_cnt_q == BDC_BIT_LAST) begin
                        bdc_d = BDC_IDLE;
                    end
                end
            endcase
        end
        bkgd_oe_d  = (bdc_d == BDC_LOW) || (bdc_d == BDC_SPEED);
        bkgd_out_d = (bdc_d == BDC_SPEED);
    end

    // Debug pin registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bdc_q      <= BDC_IDLE;
            bit_cnt_q  <= 4'h0;
            bit_val_q  <= 1'b0;
            bkgd_oe_q  <= 1'b0;
            bkgd_out_q <= 1'b0;
        end else begin
            bdc_q      <= bdc_d;
            bit_cnt_q  <= bit_cnt_d;
            bit_val_q  <= bit_val_d;
            bkgd_oe_q  <= bkgd_oe_d;
            bkgd_out_q <= bkgd_out_d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // Clock muxes live next to the oscillators; only glitch-free selects leave here
    assign hrdata                   = rdata_q;
    assign hreadyout                = ready_q;
    assign hresp                    = 1'b0;       // Always OKAY
    assign reset_pin_out            = 1'b0;       // Open-drain: only ever pulls low
    assign reset_pin_oe             = rst_oe_q;
    assign debug_modeselect_pin_out = bkgd_out_q;
    assign debug_modeselect_pin_oe  = bkgd_oe_q;
    assign peripheral_bus_clock     = bus_clk_q;
    assign main_src_sel             = ctrl_q[CTRL_MAIN_LSB+:2];
    assign timer_src_sel            = ctrl_q[CTRL_TIMER_LSB+:2];
    assign rtc_src_sel              = ctrl_q[CTRL_RTC_LSB+:2];
    assign adc_src_ext_ref          = ctrl_q[CTRL_ADC_BIT];
    assign watchdog_src_lpo         = ctrl_q[CTRL_COP_BIT];
    assign bdc_clk_sel_dco          = ctrl_q[CTRL_BDC_BIT];
    assign fixed_freq_clock         = fixed_freq_clock_q;
    assign timer_tick               = tick_q;
    assign system_reset_n           = run_q;
    assign background_mode          = mode_bdm_q;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    AST_BUS_DIV: assert property (@(posedge hclk) disable iff (!hresetn)
        bus_clk_q |=> !bus_clk_q ##1 bus_clk_q) else $error("bus clock not halved");
    AST_REG_PHASE: assert property (@(posedge hclk) disable iff (!hresetn)
        (run_q && $changed(ctrl_q)) |-> !$past(bus_clk_q)) else $error("register off phase");
    AST_MAIN_LEGAL: assert property (@(posedge hclk) disable iff (!hresetn)
        main_src_sel != 2'b11) else $error("illegal main source");
    AST_FF_HALF: assert property (@(posedge hclk) disable iff (!hresetn)
        sy.rise[SY_FF] |=> fixed_freq_clock_q != $past(fixed_freq_clock_q)) else $error("fixed clock missed edge");
    AST_FF_RATE: assert property (@(posedge hclk) disable iff (!hresetn)
        (sy.rise[SY_FF] && ff_gap_q < FF_MIN_GAP_M1) |=> ff_err_q) else $error("rate error lost");
    AST_INIT_SRC: assert property (@(posedge hclk) disable iff (!hresetn)
        !run_q |-> main_src_sel == 2'b00) else $error("not internal source in reset");
    AST_PULSE_LEN: assert property (@(posedge hclk) disable iff (!hresetn)
        $fell(reset_pin_oe) |-> $past(drive_cnt_q) == RESET_DRIVE_LAST) else $error("reset pulse length");
    AST_CAUSE_ONE: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(reset_pin_oe) |-> $onehot(cause_q)) else $error("cause not one-hot");
    AST_PIN_QUIET: assert property (@(posedge hclk) disable iff (!hresetn)
        !run_q |=> !debug_modeselect_pin_oe) else $error("debug pin driven in reset");
    AST_MODE_LATCH: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(run_q) |-> background_mode == !$past(sy.level[SY_BKGD])) else $error("mode wrong");
    AST_SPEEDUP: assert property (@(posedge hclk) disable iff (!hresetn)
        (bdc_q == BDC_SPEED) |-> (debug_modeselect_pin_oe && debug_modeselect_pin_out))
        else $error("no speedup pulse");
    AST_BIT_END: assert property (@(posedge hclk) disable iff (!hresetn)
        (bdc_q == BDC_REST && bdc_d == BDC_IDLE && run_q) |-> bit_cnt_q == BDC_BIT_LAST)
        else $error("bit time not 16");
endmodule // sys_clock_reset

/* File: test/pin_partner.sv */
// Far side: a reset switch and a debug pod on two pulled-up pins.
// Assumes the device pulls a pin only while its enable is high.
module pin_partner (
    input  logic rst_oe,
    input  logic rst_out,
    input  logic dbg_oe,
    input  logic dbg_out,
    input  logic switch_low,
    input  logic pod_low,
    output logic rst_level,
    output logic dbg_level
);
    timeunit 1ns;
    timeprecision 1ns;
    // Pull-ups hold both pins high unless a party pulls; no stale level is kept
    assign rst_level = !(rst_oe && !rst_out) && !switch_low;
    assign dbg_level = dbg_oe ? dbg_out : !pod_low;
endmodule // pin_partner

/* File: test/tb_top.sv */
// Bench: power-up, reset causes, mode pick and source selects over AHB-Lite.
// Assumes pin_partner resolves the reset and debug pins.
module tb_top;
    import clk_rst_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------
    // Stimulus and wiring
    // ------------------------------------------------------------
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, wdog = 0, slow = 0, sw = 0, pod = 0, burst = 0;
    logic [1:0] htrans = 0, msel, tsel, rsel;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
    logic hreadyout, rst_oe, rst_out, rst_in, dbg_oe, dbg_out, dbg_in, pbc, srn, bgm, adc, wds, bds, tick;
    int errors = 0, n_checks = 0;
    always #25 hclk = ~hclk;
    always #430 slow = ~slow; // Far below a quarter of the bus rate
    sys_clock_reset dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp(), .fixed_freq_source_clock(slow ^ burst),
        .timer_external_clock(slow ^ burst), .dco_local_clock(slow), .watchdog_reset_req(wdog),
        .illegal_op_req(1'b0), .illegal_addr_req(1'b0), .low_voltage_req(1'b0), .reset_pin_in(rst_in),
        .reset_pin_out(rst_out), .reset_pin_oe(rst_oe), .debug_modeselect_pin_in(dbg_in),
        .debug_modeselect_pin_out(dbg_out), .debug_modeselect_pin_oe(dbg_oe), .peripheral_bus_clock(pbc),
        .main_src_sel(msel), .timer_src_sel(tsel), .rtc_src_sel(rsel), .adc_src_ext_ref(adc),
        .watchdog_src_lpo(wds), .bdc_clk_sel_dco(bds), .fixed_freq_clock(), .timer_tick(tick),
        .system_reset_n(srn), .background_mode(bgm));
    pin_partner far_u (.rst_oe, .rst_out, .dbg_oe, .dbg_out, .switch_low(sw), .pod_low(pod),
        .rst_level(rst_in), .dbg_level(dbg_in));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Bounded wait for a high level; running out ends the run as a failure
    task automatic upto(ref logic s, input int lim);
        for (int i = 0; i < lim; i++) begin
            @(posedge hclk);
            if (s === 1'b1) return;
        end
        errors++;
        finish_test();
    endtask
    // One single-word transfer; read data kept in rd
    task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        upto(hreadyout, 20);
        htrans <= 2'h0;
        hwdata <= d;
        upto(hreadyout, 20);
        rd = hrdata;
    endtask
    task automatic after_reset(logic mode, logic [31:0] cause);
        upto(srn, 400);
        pod <= 1'b0;
        chk("mode", {31'h0, bgm}, {31'h0, mode});
        chk("main source", {30'h0, msel}, 32'h0);
        bus(1'b0, CAUSE_OFS, 32'h0);
        chk("cause", rd, cause);
        $display("reset test done");
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // Count falling edges with the pin driven, from release onwards
    task automatic power_up;
        int n;
        n = 0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        while (n < 300) begin
            @(negedge hclk);
            if (rst_oe !== 1'b1) break;
            n++;
        end
        chk("drive cycles", n, RESET_DRIVE_BUS_CYCLES * BUS_DIV);
        after_reset(1'b0, 32'h1);
    endtask
    // Main field code 3 must leave the old source in place
    task automatic selects;
        logic p;
        int t;
        t = 0;
        // With the bus clock as timer source there is one tick per bus cycle
        repeat (8) begin
            @(posedge hclk);
            t += tick;
        end
        chk("timer ticks", t, 8 / BUS_DIV);
        bus(1'b1, CTRL_OFS, 32'h1ce);
        bus(1'b1, CTRL_OFS, 32'h1cf);
        bus(1'b0, CTRL_OFS, 32'h0);
        chk("ctrl", rd, 32'h1ce);
        chk("selects", {23'h0, wds, adc, rsel, tsel, bds, msel}, 32'h1ce);
        bus(1'b0, 8'h10, 32'h0);
        chk("unmapped", rd, 32'h0);
        @(negedge hclk);
        p = pbc;
        @(negedge hclk);
        chk("bus clock", {31'h0, pbc}, {31'h0, ~p});
        $display("select test done");
    endtask
    // Internal or pin reset; the pod may hold the debug pin low through release
    task automatic cause_reset(logic pin, logic hold_dbg, logic [31:0] cause);
        @(posedge hclk);
        pod <= hold_dbg;
        sw <= pin;
        wdog <= !pin;
        @(posedge hclk);
        wdog <= 1'b0;
        repeat (3) @(posedge hclk);
        sw <= 1'b0;
        after_reset(hold_dbg, cause);
        bus(1'b0, CTRL_OFS, 32'h0);
        chk("ctrl cleared", rd, 32'h0);
    endtask
    // One debug bit: low time, one driven-high tick, then busy to the end of the bit time
    task automatic debug_bit(logic v, int low_ticks);
        int lo, hi;
        lo = 0;
        hi = 0;
        bus(1'b1, BDC_TX_OFS, {31'h0, v});
        repeat (30) begin
            @(posedge hclk);
            lo += (dbg_oe && !dbg_out && !dbg_in);
            hi += (dbg_oe && dbg_out && dbg_in);
        end
        chk("debug low", lo, low_ticks * BUS_DIV);
        chk("speedup", hi, BUS_DIV);
        bus(1'b0, STATUS_OFS, 32'h0);
        chk("busy near end", rd & 32'hf, 32'h1 << ST_BUSY);
        bus(1'b0, STATUS_OFS, 32'h0);
        chk("idle after bit", rd & 32'hf, 32'h0);
        $display("debug bit test done");
    endtask
    // Edges far too close on both clock inputs raise sticky errors; writing ones clears them
    task automatic rate_errors;
        logic [31:0] m;
        m = (32'h1 << ST_FF_ERR) | (32'h1 << ST_EXT_ERR);
        repeat (12) begin
            @(posedge hclk);
            burst <= ~burst;
        end
        repeat (20) @(posedge hclk);
        bus(1'b0, STATUS_OFS, 32'h0);
        chk("rate errors", rd & m, m);
        bus(1'b1, STATUS_OFS, m);
        bus(1'b0, STATUS_OFS, 32'h0);
        chk("rate cleared", rd & m, 32'h0);
        $display("rate test done");
    endtask
    initial begin
        power_up();
        selects();
        cause_reset(1'b0, 1'b1, 32'h4);
        cause_reset(1'b1, 1'b0, 32'h2);
        debug_bit(1'b1, BDC_LOW_ONE_M1 + 1);
        debug_bit(1'b0, BDC_LOW_ZERO_M1 + 1);
        rate_errors();
        finish_test();
    end
endmodule // tb_top
